/* File: design/uc2_pkg.sv */
`default_nettype none
package uc2_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 3;
  localparam logic [AW-1:0] ADDR_BAUD = 3'h0;
  localparam logic [AW-1:0] ADDR_CTRL1 = 3'h1;
  localparam logic [AW-1:0] ADDR_CTRL2 = 3'h2;
  localparam logic [AW-1:0] ADDR_FLAGS = 3'h3;
  localparam logic [AW-1:0] ADDR_DATA = 3'h4;
  localparam logic [AW-1:0] ADDR_ISTAT = 3'h5;
  localparam logic [AW-1:0] ADDR_IMASK = 3'h6;
  localparam logic [DW-1:0] BAUD_RST = 8'h10;
  localparam logic [DW-1:0] CTRL1_RST = 8'h00;
  localparam logic [DW-1:0] CTRL2_RST = 8'h00;
  localparam logic [DW-1:0] IMASK_RST = 8'h00;
  localparam logic [DW-1:0] ZERO8 = 8'h00;
  localparam logic [DW-1:0] ONE8 = 8'h01;
  // Fields of the first control register.
  localparam int unsigned C1_LOOP = 7;
  localparam int unsigned C1_RX_SOURCE_SEL = 5;
  localparam int unsigned C1_NINE = 4;
  localparam int unsigned C1_ROUSE = 3;
  localparam int unsigned C1_LBRK = 2;
  localparam int unsigned C1_DIR = 1;
  localparam int unsigned C1_T8 = 0;
  // Flag vector order, also the order of the enable and status bits.
  localparam int unsigned NFLAG = 4;
  localparam int unsigned FL_TXE = 3;
  localparam int unsigned FL_TC = 2;
  localparam int unsigned FL_RXF = 1;
  localparam int unsigned FL_QUIET = 0;
  // Both transmit flags stand high out of reset; the other two stand low.
  localparam logic [NFLAG-1:0] FLAGS_RST = 4'hc;
  // Bit counts of a character, a break and an idle character.
  localparam logic [3:0] DATA_LAST8 = 4'h7;
  localparam logic [3:0] DATA_LAST9 = 4'h8;
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] BRK_SHORT = 4'ha;
  localparam logic [3:0] BRK_LONG = 4'hd;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  typedef struct packed {
    logic tx_empty_irq_on;
    logic tx_done_irq_on;
    logic rx_full_irq_on;
    logic line_quiet_irq_on;
    logic xmit_on;
    logic rcv_on;
    logic rx_standby;
    logic queue_break;
  } uc2_ctrl2_t;
  typedef struct packed {
    logic oe;
    logic level;
  } uc2_pin_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_STOP = 3'b010,
    TX_BREAK = 3'b110,
    TX_PREAM = 3'b111
  } uc2_tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } uc2_rx_state_t;
endpackage
`default_nettype wire

/* File: design/uc2_serial.sv */
// Operation
// RQ1: Transmit-buffer-empty flag requests an interrupt only while its enable bit 7 is set; here irq_stat bit 3 with irq_mask bit 7 also raises irq.
// RQ2: Transmission-done flag requests an interrupt only while enable bit 6 is set; here irq_stat bit 2 with irq_mask bit 6 also raises irq.
// RQ3: Receive-full flag requests an interrupt only while enable bit 5 is set; here irq_stat bit 1 with irq_mask bit 5 also raises irq.
// RQ4: Idle-line flag requests an interrupt only while enable bit 4 is set; here irq_stat bit 0 with irq_mask bit 4 also raises irq.
// RQ5: Bit 3 turns the transmitter on and makes the serial output pin ours.
// RQ6: In single-wire mode the direction bit decides whether the line is driven.
// RQ7: Writing transmit enable 0 then 1 queues one idle character.
// RQ8: Output pin stays owned until pending data, idle and break finish; here a character still waiting in tx_hold is not waited for.
// RQ9: Bit 2 turns the receiver on; when off, the input pin is released.
// RQ10: Loopback releases the serial input pin even with the receiver on.
// RQ11: Software sets standby; hardware clears it on the chosen wakeup condition.
// RQ12: Wakeup is idle line for method 0, character MSB one for method 1.
// RQ13: Writing queue-break 1 then 0 sends one break character.
// RQ14: Break is 10/11 bit times low, 13/14 when long; repeats while set.
// RQ15: A second break may go out before software clears the bit.
// RQ16: The control register is readable and writable at any time.
// RQ17: Nine-bit mode adds a ninth data bit after eight LSB-first bits.
// RQ18: Loopback with receiver source set joins output pin, transmitter and receiver.
// RQ19: One interrupt output is high while any enabled flag is set.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module uc2_serial (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [uc2_pkg::AW-1:0] reg_addr,
  input wire logic [uc2_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [uc2_pkg::DW-1:0] reg_rdata,
  output var uc2_pkg::uc2_pin_t serial_out,
  input wire logic serial_out_in,
  input wire logic serial_in_pin,
  output logic tx_pin_owned,
  output logic rx_pin_owned,
  output logic irq
);
  import uc2_pkg::*;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] k);
    hit = (a == k);
  endfunction

  function automatic logic [3:0] data_last(input logic nine);
    data_last = nine ? DATA_LAST9 : DATA_LAST8;
  endfunction

  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = FRAME8 + {3'b000, nine};
  endfunction

  logic [DW-1:0] baud_div;
  logic [DW-1:0] ctrl1;
  uc2_ctrl2_t ctrl2;
  logic [NFLAG-1:0] irq_stat;
  logic [DW-1:0] irq_mask;
  logic [1:0] sync_in;
  logic [1:0] sync_out;
  uc2_tx_state_t tx_state;
  logic [3:0] tx_cnt;
  logic [8:0] tx_shift;
  logic [8:0] tx_hold;
  logic hold_full;
  logic tx_line;
  logic [DW-1:0] tx_div;
  logic break_pend;
  logic idle_pend;
  uc2_rx_state_t rx_state;
  logic [3:0] rx_cnt;
  logic [8:0] rx_shift;
  logic [DW-1:0] rx_div;
  logic [DW-1:0] rx_data;
  logic rx_bit8;
  logic rx_full;
  logic line_quiet;
  logic quiet_armed;
  logic [3:0] idle_cnt;
  logic [NFLAG-1:0] flags_q;

  logic loop_sel;
  logic one_wire;
  logic nine;
  logic wr_ctrl2;
  logic rd_data;
  logic tx_tick;
  logic rx_tick;
  logic tx_idle;
  logic break_start;
  logic idle_start;
  logic tx_load;
  logic rx_line;
  logic rx_done;
  logic rx_accept;
  logic quiet_hit;
  logic wake;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] enables;
  logic next_tx_owned;

  assign loop_sel = ctrl1[C1_LOOP];
  assign one_wire = ctrl1[C1_LOOP] & ctrl1[C1_RX_SOURCE_SEL];
  assign nine = ctrl1[C1_NINE];
  assign wr_ctrl2 = reg_wr & hit(reg_addr, ADDR_CTRL2);
  assign rd_data = reg_rd & hit(reg_addr, ADDR_DATA);
  assign tx_idle = (tx_state == TX_IDLE);
  assign flags[FL_TXE] = ~hold_full;
  assign flags[FL_TC] = ~hold_full & tx_idle & ~break_pend & ~idle_pend & ~ctrl2.queue_break;
  assign flags[FL_RXF] = rx_full;
  assign flags[FL_QUIET] = line_quiet;
  assign enables = {ctrl2.tx_empty_irq_on, ctrl2.tx_done_irq_on,
                    ctrl2.rx_full_irq_on, ctrl2.line_quiet_irq_on};

  ////////////////////////////////////////////////////////////////////////////////
  // Register port. Reads answer in the next cycle only and show zero otherwise.

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      baud_div <= BAUD_RST;
      ctrl1 <= CTRL1_RST;
      irq_mask <= IMASK_RST;
    end
    else if (clk_en && reg_wr)
    begin
      if (hit(reg_addr, ADDR_BAUD))
        baud_div <= reg_wdata;
      if (hit(reg_addr, ADDR_CTRL1))
        ctrl1 <= reg_wdata;
      if (hit(reg_addr, ADDR_IMASK))
        irq_mask <= reg_wdata;
    end
  end

  // A software write wins over the wakeup clear so a fresh standby request is never lost.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ctrl2 <= uc2_ctrl2_t'(CTRL2_RST);
    else if (clk_en)
    begin
      if (wr_ctrl2)
        ctrl2 <= uc2_ctrl2_t'(reg_wdata); // RQ16
      else if (wake)
        ctrl2.rx_standby <= 1'b0; // RQ11
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= ZERO8;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata <= ZERO8;
      else
        case (reg_addr)
          ADDR_BAUD: reg_rdata <= baud_div;
          ADDR_CTRL1: reg_rdata <= ctrl1;
          ADDR_CTRL2: reg_rdata <= ctrl2; // RQ16
          ADDR_FLAGS: reg_rdata <= {flags, 3'b000, rx_bit8};
          ADDR_DATA: reg_rdata <= rx_data;
          ADDR_ISTAT: reg_rdata <= {irq_stat, 4'h0};
          ADDR_IMASK: reg_rdata <= irq_mask;
          default: reg_rdata <= ZERO8;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: level requests from the enabled flags plus sticky edge events.

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      flags_q <= FLAGS_RST;
    else if (clk_en)
      flags_q <= flags;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++)
    begin : g_stat
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          irq_stat[gi] <= 1'b0;
        else if (clk_en)
        begin
          if (flags[gi] && !flags_q[gi])
            irq_stat[gi] <= 1'b1;
          else if (reg_wr && hit(reg_addr, ADDR_ISTAT) && reg_wdata[gi + NFLAG])
            irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else if (clk_en)
      irq <= (|(enables & flags)) | (|(irq_stat & irq_mask[DW-1:NFLAG])); // RQ1 RQ2 RQ3 RQ4 RQ19
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin inputs and receiver source selection.

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_in <= 2'b11;
      sync_out <= 2'b11;
    end
    else if (clk_en)
    begin
      sync_in <= {sync_in[0], serial_in_pin};
      sync_out <= {sync_out[0], serial_out_in};
    end
  end

  // While the single line is driven the receiver hears its own transmitter.
  always_comb
  begin
    if (!loop_sel)
      rx_line = sync_in[1];
    else if (one_wire && !ctrl1[C1_DIR])
      rx_line = sync_out[1]; // RQ6 RQ18
    else
      rx_line = tx_line; // RQ18
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter. Breaks go first, then a queued idle, then buffered data.

  assign tx_tick = (baud_div != ZERO8) && (tx_div == baud_div - ONE8);
  assign break_start = tx_tick & tx_idle & (break_pend | ctrl2.queue_break); // RQ13 RQ14 RQ15
  assign idle_start = tx_tick & tx_idle & ~break_start & idle_pend; // RQ7
  assign tx_load = tx_tick & tx_idle & ~break_start & ~idle_pend & hold_full & ctrl2.xmit_on; // RQ5

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      tx_div <= ZERO8;
    else if (clk_en)
      tx_div <= tx_tick ? ZERO8 : tx_div + ONE8;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      break_pend <= 1'b0;
      idle_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl2 && reg_wdata[0] && !ctrl2.queue_break)
        break_pend <= 1'b1; // RQ13
      else if (break_start)
        break_pend <= 1'b0;
      if (wr_ctrl2 && reg_wdata[3] && !ctrl2.xmit_on)
        idle_pend <= 1'b1; // RQ7
      else if (idle_start)
        idle_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      hold_full <= 1'b0;
      tx_hold <= 9'h000;
    end
    else if (clk_en)
    begin
      if (reg_wr && hit(reg_addr, ADDR_DATA))
      begin
        hold_full <= 1'b1;
        tx_hold <= {ctrl1[C1_T8], reg_wdata}; // RQ17
      end
      else if (tx_load)
        hold_full <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_state <= TX_IDLE;
      tx_cnt <= CNT_ZERO;
      tx_shift <= 9'h000;
      tx_line <= 1'b1;
    end
    else if (clk_en && tx_tick)
    begin
      case (tx_state)
        TX_IDLE:
        begin
          tx_line <= ~(break_start | tx_load);
          if (break_start)
          begin
            tx_state <= TX_BREAK;
            tx_cnt <= (ctrl1[C1_LBRK] ? BRK_LONG : BRK_SHORT) + {3'b000, nine} - CNT_ONE; // RQ14
          end
          else if (idle_start)
          begin
            tx_state <= TX_PREAM;
            tx_cnt <= frame_len(nine) - CNT_ONE;
          end
          else if (tx_load)
          begin
            tx_state <= TX_START;
            tx_shift <= tx_hold;
          end
        end
        TX_START:
        begin
          tx_state <= TX_DATA;
          tx_line <= tx_shift[0];
          tx_cnt <= data_last(nine); // RQ17
        end
        TX_DATA:
        begin
          if (tx_cnt == CNT_ZERO)
          begin
            tx_state <= TX_STOP;
            tx_line <= 1'b1;
          end
          else
          begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_line <= tx_shift[1];
            tx_cnt <= tx_cnt - CNT_ONE;
          end
        end
        TX_STOP, TX_BREAK, TX_PREAM:
        begin
          if (tx_cnt == CNT_ZERO)
          begin
            tx_state <= TX_IDLE;
            tx_line <= 1'b1;
          end
          else
            tx_cnt <= tx_cnt - CNT_ONE;
        end
        default:
        begin
          tx_state <= TX_IDLE;
          tx_line <= 1'b1;
        end
      endcase
    end
  end

  // Ownership outlives the enable until the shifter is idle and no break or idle is pending; a character still in tx_hold is not waited for.
  assign next_tx_owned = ctrl2.xmit_on | ~tx_idle | break_pend | idle_pend; // RQ5 RQ8

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_pin_owned <= 1'b0;
      serial_out <= '{oe: 1'b0, level: 1'b1};
      rx_pin_owned <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_pin_owned <= next_tx_owned; // RQ8
      serial_out.oe <= next_tx_owned & ~(one_wire & ~ctrl1[C1_DIR]); // RQ5 RQ6
      serial_out.level <= tx_line;
      rx_pin_owned <= ctrl2.rcv_on & ~loop_sel; // RQ9 RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver. Samples mid-bit; the start bit is checked once more before data.

  assign rx_tick = (baud_div != ZERO8) && (rx_div == ZERO8);
  assign rx_done = rx_tick & (rx_state == RX_STOP);
  // The MSB of either character size lands in bit 8 of the shifter.
  assign rx_accept = rx_done & rx_line & (~ctrl2.rx_standby | (ctrl1[C1_ROUSE] & rx_shift[8]));
  assign quiet_hit = rx_tick & (rx_state == RX_IDLE) & rx_line &
                     (idle_cnt == frame_len(nine) - CNT_ONE);
  assign wake = ctrl2.rx_standby & (ctrl1[C1_ROUSE] ? (rx_done & rx_shift[8]) : quiet_hit); // RQ12

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      rx_div <= ZERO8;
    else if (clk_en)
    begin
      if (rx_state == RX_IDLE && !rx_line && ctrl2.rcv_on)
        rx_div <= {1'b0, baud_div[DW-1:1]};
      else if (rx_tick)
        rx_div <= baud_div - ONE8;
      else if (rx_div != ZERO8)
        rx_div <= rx_div - ONE8;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_state <= RX_IDLE;
      rx_cnt <= CNT_ZERO;
      rx_shift <= 9'h000;
    end
    else if (clk_en)
    begin
      case (rx_state)
        RX_IDLE:
          if (!rx_line && ctrl2.rcv_on) // RQ9
            rx_state <= RX_START;
        RX_START:
          if (rx_tick)
          begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt <= data_last(nine); // RQ17
          end
        RX_DATA:
          if (rx_tick)
          begin
            rx_shift <= {rx_line, rx_shift[8:1]};
            rx_cnt <= rx_cnt - CNT_ONE;
            if (rx_cnt == CNT_ZERO)
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
            rx_state <= RX_IDLE;
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_data <= ZERO8;
      rx_bit8 <= 1'b0;
    end
    else if (clk_en && rx_accept)
    begin
      rx_data <= nine ? rx_shift[7:0] : rx_shift[8:1]; // RQ17
      rx_bit8 <= nine & rx_shift[8];
    end
  end

  // Flags set by hardware win over the clearing data read in the same cycle.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_full <= 1'b0;
      line_quiet <= 1'b0;
      quiet_armed <= 1'b0;
      idle_cnt <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      if (rx_accept)
        rx_full <= 1'b1;
      else if (rd_data)
        rx_full <= 1'b0;
      if (quiet_hit && quiet_armed && !ctrl2.rx_standby)
        line_quiet <= 1'b1;
      else if (rd_data)
        line_quiet <= 1'b0;
      if (rx_accept)
        quiet_armed <= 1'b1;
      else if (quiet_hit)
        quiet_armed <= 1'b0;
      if (!rx_line || rx_state != RX_IDLE)
        idle_cnt <= CNT_ZERO;
      else if (rx_tick && idle_cnt != frame_len(nine))
        idle_cnt <= idle_cnt + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence ctrl_read_s;
    clk_en && reg_rd && hit(reg_addr, ADDR_CTRL2);
  endsequence

  sequence xmit_rise_s;
    clk_en && wr_ctrl2 && reg_wdata[3] && !ctrl2.xmit_on;
  endsequence

  irq_enabled_a: assert property (clk_en && |(enables & flags) |=> irq) // RQ1 RQ2 RQ3 RQ4 RQ19
    else $error("enabled flag gave no interrupt");
  irq_silent_a: assert property (clk_en && !(|(enables & flags)) && // RQ19
    !(|(irq_stat & irq_mask[DW-1:NFLAG])) |=> !irq)
    else $error("interrupt without enabled source");
  xmit_drive_a: assert property (clk_en && ctrl2.xmit_on && !(one_wire && !ctrl1[C1_DIR]) // RQ5
    |=> serial_out.oe)
    else $error("transmitter on but pin not driven");
  owner_hold_a: assert property (clk_en && (!tx_idle || break_pend || idle_pend) // RQ8
    |=> tx_pin_owned)
    else $error("pin released with work pending");
  rx_release_a: assert property (clk_en && loop_sel |=> !rx_pin_owned) // RQ10
    else $error("input pin held in loopback");
  rx_owned_a: assert property (clk_en && ctrl2.rcv_on && !loop_sel |=> rx_pin_owned) // RQ9
    else $error("receiver on but input pin not owned");
  idle_queue_a: assert property (xmit_rise_s |=> idle_pend) // RQ7
    else $error("idle character not queued");
  break_low_a: assert property (clk_en && break_start |=> // RQ13 RQ14
    tx_state == TX_BREAK ##0 !tx_line)
    else $error("break did not start low");
  wake_mark_a: assert property (clk_en && ctrl2.rx_standby && ctrl1[C1_ROUSE] && // RQ11 RQ12
    rx_done && rx_shift[8] && !wr_ctrl2 |=> !ctrl2.rx_standby)
    else $error("address mark did not wake receiver");
  one_wire_a: assert property (clk_en && one_wire && !ctrl1[C1_DIR] |=> !serial_out.oe) // RQ6
    else $error("single-wire line driven while receiving");
  ctrl_read_a: assert property (ctrl_read_s |=> reg_rdata == $past(ctrl2)) // RQ16
    else $error("control register read mismatch");
endmodule
`default_nettype wire

/* File: sim/uc2_remote_node.sv */
`timescale 1ns/10ps
`default_nettype none
module uc2_remote_node #(
  parameter int BIT_T = 16
) (
  input wire logic core_clk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  logic [7:0] rx_byte = 8'h00;
  int rx_count = 0;
  int low_run = 0;
  int last_low = 0;
  int low_events = 0;

  initial line_to_dut = 1'b1;

  ////////////////////////////////////////
  // The line rests high between frames, so a released line never holds a stale bit.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge core_clk);
    for (int i = 0; i < 10; i++)
    begin
      line_to_dut <= f[i];
      repeat (BIT_T) @(posedge core_clk);
    end
  endtask

  ////////////////////////////////////////
  // Sampling on the falling clock edge keeps clear of the transmitter's own updates.
  always
  begin
    @(negedge line_from_dut);
    repeat (BIT_T / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_T) @(negedge core_clk);
      rx_byte[i] = line_from_dut;
    end
    repeat (BIT_T) @(negedge core_clk);
    rx_count++;
    if (!line_from_dut)
      @(posedge line_from_dut);
  end

  always @(negedge core_clk)
  begin
    if (!line_from_dut)
      low_run <= low_run + 1;
    else if (low_run != 0)
    begin
      last_low <= low_run;
      low_events <= low_events + 1;
      low_run <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/test_uart_control_two.sv */
`timescale 1ns/10ps
`default_nettype none
module test_uart_control_two;
  import uc2_pkg::*;
  localparam int BIT_T = int'(BAUD_RST);
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  uc2_pin_t serial_out;
  logic serial_out_line;
  logic remote_line;
  logic tx_pin_owned;
  logic rx_pin_owned;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] d;
  logic [7:0] r;
  logic [7:0] sent;
  logic clk_en = 1'b1;

  always #2 core_clk = ~core_clk;
  // A released single-wire line is pulled high, as an idle serial line rests.
  assign serial_out_line = serial_out.oe ? serial_out.level : 1'b1;

  uc2_serial dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_out(serial_out), .serial_out_in(serial_out_line), .serial_in_pin(remote_line),
    .tx_pin_owned(tx_pin_owned), .rx_pin_owned(rx_pin_owned), .irq(irq)
  );
  uc2_remote_node #(.BIT_T(BIT_T)) remote (
    .core_clk(core_clk), .line_from_dut(serial_out_line), .line_to_dut(remote_line)
  );

  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_frame;
    int b;
    b = remote.rx_count;
    for (int i = 0; i < 2000 && remote.rx_count == b; i++)
      @(posedge core_clk);
    chk(8'(remote.rx_count != b), 8'h01);
  endtask

  // One break is 10 or 11 bit times, 13 or 14 when long; a second one may follow straight on.
  function automatic logic [7:0] brk_ok(input int run, input int lo);
    return 8'((run >= lo && run <= lo + BIT_T) || (run >= 2 * lo && run <= 2 * lo + 2 * BIT_T));
  endfunction

  task automatic enables_loop;
    for (int k = 0; k < 8; k++)
    begin
      r = (k == 0) ? 8'h30 : 8'($urandom) & 8'hf4;
      wr(ADDR_CTRL2, r);
      rd(ADDR_CTRL2, d);
      chk(d, r);
      rd(ADDR_FLAGS, d);
      chk(8'(irq), 8'(|(r[7:4] & d[7:4])));
      chk(8'(rx_pin_owned), 8'(r[2]));
    end
  endtask

  task automatic brk(input logic [7:0] c1, input int lo);
    int e;
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CTRL2, 8'h09);
    wr(ADDR_CTRL2, 8'h08);
    e = remote.low_events;
    for (int i = 0; i < 1000 && remote.low_events == e; i++)
      @(posedge core_clk);
    chk(brk_ok(remote.last_low, lo), 8'h01);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    cyc(20000);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h9e81));
    cyc(10);
    reset <= 1'b0;
    rd(ADDR_CTRL2, d);
    chk(d, CTRL2_RST);
    wr(3'h7, 8'hff);
    rd(3'h7, d);
    chk(d, ZERO8);
    enables_loop();
    $display("Enable test done");
    wr(ADDR_CTRL2, 8'h04);
    sent = 8'($urandom);
    remote.send(sent);
    cyc(40);
    enables_loop();
    wr(ADDR_CTRL2, 8'h04);
    cyc(2);
    chk(8'(irq), 8'h00);
    wr(ADDR_IMASK, 8'h20);
    cyc(2);
    chk(8'(irq), 8'h01);
    wr(ADDR_ISTAT, 8'h20);
    cyc(2);
    chk(8'(irq), 8'h00);
    wr(ADDR_IMASK, 8'h00);
    rd(ADDR_DATA, d);
    chk(d, sent);
    $display("Receive test done");
    wr(ADDR_CTRL1, 8'h08);
    wr(ADDR_CTRL2, 8'h06);
    remote.send(8'h35);
    cyc(40);
    rd(ADDR_CTRL2, d);
    chk(d, 8'h06);
    remote.send(8'hb5);
    cyc(40);
    rd(ADDR_CTRL2, d);
    chk(d, 8'h04);
    rd(ADDR_DATA, d);
    chk(d, 8'hb5);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL2, 8'h06);
    remote.send(8'h35);
    cyc(400);
    rd(ADDR_CTRL2, d);
    chk(d, 8'h04);
    rd(ADDR_DATA, d);
    $display("Standby test done");
    wr(ADDR_CTRL1, 8'h80);
    cyc(3);
    chk(8'(rx_pin_owned), 8'h00);
    wr(ADDR_CTRL1, 8'h00);
    cyc(3);
    chk(8'(rx_pin_owned), 8'h01);
    wr(ADDR_CTRL2, 8'h08);
    cyc(3);
    chk(8'({tx_pin_owned, serial_out.oe}), 8'h03);
    r = 8'($urandom);
    wr(ADDR_DATA, r);
    wait_frame();
    chk(remote.rx_byte, r);
    r = 8'($urandom);
    wr(ADDR_DATA, r);
    cyc(40);
    wr(ADDR_CTRL2, 8'h00);
    cyc(60);
    chk(8'(tx_pin_owned), 8'h01);
    wait_frame();
    chk(remote.rx_byte, r);
    cyc(40);
    chk(8'(tx_pin_owned), 8'h00);
    $display("Transmit test done");
    brk(8'h00, 10 * BIT_T);
    brk(8'h04, 13 * BIT_T);
    $display("Break test done");
    wr(ADDR_CTRL1, 8'ha0);
    cyc(3);
    chk(8'(serial_out.oe), 8'h00);
    wr(ADDR_CTRL1, 8'ha2);
    wr(ADDR_CTRL2, 8'h0c);
    cyc(3);
    chk(8'(serial_out.oe), 8'h01);
    r = 8'($urandom);
    wr(ADDR_DATA, r);
    wait_frame();
    cyc(40);
    rd(ADDR_DATA, d);
    chk(d, r);
    $display("Single-wire test done");
    wr(ADDR_CTRL1, 8'hb3);
    r = 8'($urandom);
    wr(ADDR_DATA, r);
    wait_frame();
    cyc(60);
    rd(ADDR_DATA, d);
    chk(d, r);
    rd(ADDR_FLAGS, d);
    chk(8'(d[0]), 8'h01);
    $display("Nine-bit test done");
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_CTRL2, 8'hff);
    clk_en <= 1'b1;
    rd(ADDR_CTRL2, d);
    chk(d, 8'h0c);
    $display("Freeze test done");
    print_verdict();
  end
endmodule
`default_nettype wire
